// File: rtl/phb_bus_if.sv
// Shared local bus wires; every two-way pin carries out, active-low enable.
// Assumes the testbench resolves wire levels from both ends' enables.
`timescale 1ns/1ps
interface phb_bus_if;
    logic [31:0] ad_dev_o;
    logic        ad_dev_oe_n;
    logic [31:0] ad_ext_o;
    logic        ad_ext_oe_n;
    logic [31:0] ad_i;
    logic [3:0]  cbe_n_dev_o;
    logic        cbe_dev_oe_n;
    logic [3:0]  cbe_n_ext_o;
    logic        cbe_ext_oe_n;
    logic [3:0]  cbe_n_i;
    logic        par_dev_o;
    logic        par_dev_oe_n;
    logic        par_ext_o;
    logic        par_ext_oe_n;
    logic        par_i;
    logic        frame_n_ext_o;
    logic        frame_ext_oe_n;
    logic        frame_n_i;
    logic        irdy_n_ext_o;
    logic        irdy_ext_oe_n;
    logic        irdy_n_i;
    logic        trdy_n_dev_o;
    logic        trdy_dev_oe_n;
    logic        trdy_n_i;
    logic        stop_n_dev_o;
    logic        stop_dev_oe_n;
    logic        stop_n_i;
    logic        devsel_n_dev_o;
    logic        devsel_dev_oe_n;
    logic        devsel_n_i;
    logic        lock_n_i;
    logic [2:0]  master_request_n;
    logic [2:0]  master_grant_n;
    logic [3:0]  int_n;
    logic        serr_n;
    logic        bus_reset_out_n;

    modport dev (
        output ad_dev_o, ad_dev_oe_n, cbe_n_dev_o, cbe_dev_oe_n,
        output par_dev_o, par_dev_oe_n, trdy_n_dev_o, trdy_dev_oe_n,
        output stop_n_dev_o, stop_dev_oe_n, devsel_n_dev_o,
        output devsel_dev_oe_n, master_grant_n, bus_reset_out_n,
        input  ad_i, cbe_n_i, par_i, frame_n_i, irdy_n_i, trdy_n_i,
        input  stop_n_i, devsel_n_i, lock_n_i, master_request_n,
        input  int_n, serr_n
    );
    modport ext (
        output ad_ext_o, ad_ext_oe_n, cbe_n_ext_o, cbe_ext_oe_n,
        output par_ext_o, par_ext_oe_n, frame_n_ext_o, frame_ext_oe_n,
        output irdy_n_ext_o, irdy_ext_oe_n, master_request_n, int_n,
        output serr_n,
        input  ad_i, cbe_n_i, par_i, frame_n_i, irdy_n_i, trdy_n_i,
        input  stop_n_i, devsel_n_i, master_grant_n, bus_reset_out_n
    );
endinterface : phb_bus_if

// File: rtl/phb_device_end.sv
// Chipset end: target engine, arbiter, lock, interrupts, error and reset.
// Assumes pin inputs are asynchronous and passes them two flip-flops.
`timescale 1ns/1ps
module phb_device_end #(
    parameter int unsigned RESET_HOLD = phb_pkg::RESET_HOLD_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    phb_bus_if.dev           bus,
    input  wire logic        main_power_good,
    input  wire logic        nmi_enable,
    input  wire logic [31:0] rd_data,
    input  wire logic [7:0]  int_route,
    output logic             wr_strobe,
    output logic [31:0]      wr_data,
    output logic [31:0]      cyc_addr,
    output logic [3:0]       cyc_cmd,
    output logic             locked,
    output logic [3:0]       irq_to_ctrl,
    output logic             nmi
);
    localparam int W = 32 + 4 + 1 + 1 + 1 + 1 + 1 + 3 + 4 + 1 + 1;
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [31:0]  ad;
    logic [3:0]   cbe_n;
    logic         frame_n;
    logic         irdy_n;
    logic         devsel_n_in;
    logic         lock_n;
    logic         serr_n;
    logic [2:0]   req_n;
    logic [3:0]   int_n;
    logic         pgood;
    logic         stop_unused;

    always_ff @(posedge core_clk) begin
        s1_reg <= {bus.ad_i, bus.cbe_n_i, bus.frame_n_i, bus.irdy_n_i,
                   bus.devsel_n_i, bus.lock_n_i, bus.serr_n,
                   bus.master_request_n, bus.int_n, main_power_good,
                   bus.stop_n_i};
        s2_reg <= s1_reg;
    end
    // Parity input is never sampled: no check and no error flag.
    assign {ad, cbe_n, frame_n, irdy_n, devsel_n_in, lock_n, serr_n,
            req_n, int_n, pgood, stop_unused} = s2_reg;

    logic drive_ad;
    logic active;
    logic trdy_n;
    logic devsel_n;

    phb_target u_target (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .frame_n     (frame_n),
        .irdy_n      (irdy_n),
        .devsel_in_n (devsel_n_in),
        .ad_in       (ad),
        .cbe_n_in    (cbe_n),
        .rd_data     (rd_data),
        .active      (active),
        .drive_ad    (drive_ad),
        .trdy_n      (trdy_n),
        .devsel_n    (devsel_n),
        .wr_strobe   (wr_strobe),
        .wr_data     (wr_data),
        .cyc_addr    (cyc_addr),
        .cyc_cmd     (cyc_cmd)
    );

    logic [31:0] ad_out_reg;
    logic        ad_oe_reg;
    logic        par_oe_reg;
    logic        par_reg;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ad_out_reg <= 32'h0;
            ad_oe_reg  <= 1'b0;
            par_reg    <= 1'b0;
            par_oe_reg <= 1'b0;
        end else begin
            ad_out_reg <= rd_data;
            ad_oe_reg  <= drive_ad;
            // Parity trails its data phase by one clock.
            par_reg    <= phb_pkg::even_parity(ad_out_reg, cbe_n);
            par_oe_reg <= ad_oe_reg;
        end
    end
    assign bus.ad_dev_o        = ad_out_reg;
    assign bus.ad_dev_oe_n     = ~ad_oe_reg;
    assign bus.par_dev_o       = par_reg;
    assign bus.par_dev_oe_n    = ~par_oe_reg;
    // This end never masters, so command lines stay released.
    assign bus.cbe_n_dev_o     = 4'hf;
    assign bus.cbe_dev_oe_n    = 1'b1;
    assign bus.trdy_n_dev_o    = trdy_n;
    assign bus.trdy_dev_oe_n   = ~active;
    assign bus.devsel_n_dev_o  = devsel_n;
    assign bus.devsel_dev_oe_n = ~active;
    assign bus.stop_n_dev_o    = 1'b1;
    assign bus.stop_dev_oe_n   = 1'b1;

    logic frame_d_reg;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            frame_d_reg <= 1'b1;
            locked      <= 1'b0;
        end else begin
            frame_d_reg <= frame_n;
            if (frame_d_reg && !frame_n && !lock_n) begin
                locked <= 1'b1;
            end else if (lock_n) begin
                locked <= 1'b0;
            end
        end
    end

    // Round robin; a grant is held until its request and frame drop.
    logic [2:0] grant_reg;
    logic [1:0] last_reg;
    logic [1:0] pick;
    logic       any_req;
    always_comb begin
        pick    = last_reg;
        any_req = 1'b0;
        for (int i = 1; i <= 3; i++) begin
            logic [1:0] idx;
            idx = 2'((int'(last_reg) + i) % phb_pkg::NUM_MASTERS);
            if (!any_req && !req_n[idx]) begin
                pick    = idx;
                any_req = 1'b1;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            grant_reg <= 3'h0;
            last_reg  <= 2'h0;
        end else if (grant_reg == 3'h0) begin
            if (any_req && frame_n) begin
                grant_reg <= 3'(1 << pick);
                last_reg  <= pick;
            end
        end else if ((grant_reg & ~req_n) == 3'h0 && frame_n) begin
            grant_reg <= 3'h0;
        end
    end
    assign bus.master_grant_n = ~grant_reg;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irq_to_ctrl <= 4'h0;
            nmi         <= 1'b0;
        end else begin
            for (int k = 0; k < 4; k++) begin
                irq_to_ctrl[k] <= !int_n[int_route[2*k +: 2]];
            end
            nmi <= nmi_enable && !serr_n;
        end
    end

    logic [$clog2(RESET_HOLD+1)-1:0] hold_reg;
    logic rst_out_reg;
    always_ff @(posedge core_clk) begin
        if (!rst_b || !pgood) begin
            hold_reg    <= '0;
            rst_out_reg <= 1'b0;
        end else if (rst_out_reg == 1'b0) begin
            if (hold_reg == $bits(hold_reg)'(RESET_HOLD - 1)) begin
                rst_out_reg <= 1'b1;
            end else begin
                hold_reg <= hold_reg + 1'b1;
            end
        end
    end
    assign bus.bus_reset_out_n = rst_out_reg;
endmodule : phb_device_end

// File: rtl/phb_ext_master.sv
// External agent end: requests the bus and runs one single-phase cycle.
// Assumes bus inputs are asynchronous and passes them two flip-flops, except bus_reset_out_n, which is used directly.
`timescale 1ns/1ps
module phb_ext_master (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    phb_bus_if.ext           bus,
    input  wire logic        start,
    input  wire logic [31:0] addr,
    input  wire logic [3:0]  cmd,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  irq_n,
    input  wire logic        serr_req,
    output logic             busy,
    output logic             done,
    output logic             no_claim,
    output logic [31:0]      rdata
);
    typedef enum logic [2:0] {
        PHE_IDLE, PHE_REQ, PHE_ADDR, PHE_DATA, PHE_END
    } phe_state_t;
    phe_state_t  state_reg;
    logic [31:0] ad_s1_reg;
    logic [31:0] ad_s2_reg;
    logic [3:0]  c1_reg;
    logic [3:0]  c2_reg;
    logic        trdy_n;
    logic        devsel_n;
    logic        stop_n;
    logic        gnt_n;
    logic [3:0]  cmd_reg;
    logic [31:0] addr_reg;
    logic [31:0] wdata_reg;
    logic [2:0]  wait_reg;
    logic        rd;
    always_ff @(posedge core_clk) begin
        ad_s1_reg <= bus.ad_i;
        ad_s2_reg <= ad_s1_reg;
        c1_reg <= {bus.trdy_n_i, bus.devsel_n_i, bus.stop_n_i,
                   bus.master_grant_n[0]};
        c2_reg <= c1_reg;
    end
    assign {trdy_n, devsel_n, stop_n, gnt_n} = c2_reg;
    assign rd = phb_pkg::is_read(cmd_reg);
    always_ff @(posedge core_clk) begin
        if (!rst_b || !bus.bus_reset_out_n) begin
            state_reg <= PHE_IDLE;
            cmd_reg   <= 4'h0;
            addr_reg  <= 32'h0;
            wdata_reg <= 32'h0;
            rdata     <= 32'h0;
            done      <= 1'b0;
            no_claim  <= 1'b0;
            wait_reg  <= 3'h0;
        end else begin
            done <= 1'b0;
            case (state_reg)
                PHE_IDLE: if (start) begin
                    cmd_reg   <= cmd;
                    addr_reg  <= addr;
                    wdata_reg <= wdata;
                    no_claim  <= 1'b0;
                    wait_reg  <= 3'h0;
                    state_reg <= PHE_REQ;
                end
                // A grant seen in the first cycles may be the stale one of
                // the last cycle, still travelling through the synchronisers.
                PHE_REQ: if (wait_reg != 3'h3) begin
                    wait_reg <= wait_reg + 3'h1;
                end else if (!gnt_n) begin
                    state_reg <= PHE_ADDR;
                end
                PHE_ADDR: begin
                    wait_reg  <= 3'h0;
                    state_reg <= PHE_DATA;
                end
                PHE_DATA: begin
                    wait_reg <= wait_reg + 3'h1;
                    if (!trdy_n && !devsel_n) begin
                        if (rd) rdata <= ad_s2_reg;
                        done      <= 1'b1;
                        state_reg <= PHE_END;
                    end else if (!stop_n) begin
                        done      <= 1'b1;
                        state_reg <= PHE_END;
                    end else if (devsel_n && wait_reg == 3'h7) begin
                        no_claim  <= 1'b1;
                        done      <= 1'b1;
                        state_reg <= PHE_END;
                    end
                end
                PHE_END: state_reg <= PHE_IDLE;
                default: state_reg <= PHE_IDLE;
            endcase
        end
    end
    assign busy = state_reg != PHE_IDLE;
    logic mastering;
    assign mastering = state_reg == PHE_ADDR || state_reg == PHE_DATA;
    assign bus.master_request_n[0] = ~(state_reg == PHE_REQ || mastering);
    assign bus.frame_n_ext_o  = ~(state_reg == PHE_ADDR);
    assign bus.frame_ext_oe_n = ~(mastering || state_reg == PHE_END);
    assign bus.irdy_n_ext_o   = ~(state_reg == PHE_DATA);
    assign bus.irdy_ext_oe_n  = ~(mastering || state_reg == PHE_END);
    assign bus.ad_ext_o = (state_reg == PHE_ADDR) ? addr_reg : wdata_reg;
    assign bus.ad_ext_oe_n = ~(state_reg == PHE_ADDR
                            || (state_reg == PHE_DATA && !rd));
    assign bus.cbe_n_ext_o  = (state_reg == PHE_ADDR) ? ~cmd_reg : 4'h0;
    assign bus.cbe_ext_oe_n = ~mastering;
    assign bus.par_ext_o    = 1'b0;
    assign bus.par_ext_oe_n = 1'b1;
    assign bus.int_n        = irq_n;
    assign bus.serr_n       = ~serr_req;
endmodule : phb_ext_master

// File: rtl/phb_pkg.sv
// Constants and functions shared by both ends of the local bus bridge link.
// Assumes one 10 MHz clock on both ends and a testbench resolving pins.
package phb_pkg;
    localparam int unsigned CLK_HZ          = 10_000_000;
    localparam int unsigned RESET_HOLD_MS   = 24;
    localparam int unsigned RESET_HOLD_CYC  =
        CLK_HZ / 1000 * RESET_HOLD_MS;
    localparam int unsigned NUM_MASTERS     = 3;
    localparam int unsigned SUBTR_DELAY     = 3;

    localparam logic [3:0]  CMD_IO_RD       = 4'h2;
    localparam logic [3:0]  CMD_IO_WR       = 4'h3;
    localparam logic [3:0]  CMD_MEM_RD      = 4'h6;
    localparam logic [3:0]  CMD_MEM_WR      = 4'h7;
    localparam logic [3:0]  CMD_CFG_RD      = 4'ha;
    localparam logic [3:0]  CMD_CFG_WR      = 4'hb;

    localparam logic [31:0] IO_LOW_LIMIT    = 32'h0000_4000;
    localparam logic [31:0] MEM_LOW_LIMIT   = 32'h0100_0000;
    localparam logic [31:0] DRAM_BASE       = 32'h1000_0000;
    localparam logic [31:0] DRAM_LIMIT      = 32'h2000_0000;
    localparam logic [31:0] BOOT_BASE       = 32'hfff0_0000;
    localparam logic [31:0] EMB_IO_BASE     = 32'h0000_f000;
    localparam logic [31:0] EMB_IO_LIMIT    = 32'h0000_f100;

    function automatic logic even_parity(input logic [31:0] ad,
                                         input logic [3:0]  cbe);
        even_parity = ^{ad, cbe};
    endfunction : even_parity

    function automatic logic is_read(input logic [3:0] cmd);
        is_read = (cmd == CMD_IO_RD) || (cmd == CMD_MEM_RD)
                || (cmd == CMD_CFG_RD);
    endfunction : is_read
endpackage : phb_pkg

// File: rtl/phb_target.sv
// Target-side data phase engine with positive and subtractive decode.
// Assumes all bus inputs are already synchronised to core_clk.
`timescale 1ns/1ps
module phb_target (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        frame_n,
    input  wire logic        irdy_n,
    input  wire logic        devsel_in_n,
    input  wire logic [31:0] ad_in,
    input  wire logic [3:0]  cbe_n_in,
    input  wire logic [31:0] rd_data,
    output logic             active,
    output logic             drive_ad,
    output logic             trdy_n,
    output logic             devsel_n,
    output logic             wr_strobe,
    output logic [31:0]      wr_data,
    output logic [31:0]      cyc_addr,
    output logic [3:0]       cyc_cmd
);
    typedef enum logic [2:0] {
        PHT_IDLE, PHT_DECODE, PHT_DATA, PHT_TURN
    } pht_state_t;

    pht_state_t state_reg;
    logic [1:0] wait_reg;
    logic       positive;
    logic       subtract;
    logic       mem_cmd;
    logic       io_cmd;
    logic       cfg_cmd;
    logic       owned;

    assign mem_cmd = (cyc_cmd == phb_pkg::CMD_MEM_RD)
                   || (cyc_cmd == phb_pkg::CMD_MEM_WR);
    assign io_cmd  = (cyc_cmd == phb_pkg::CMD_IO_RD)
                   || (cyc_cmd == phb_pkg::CMD_IO_WR);
    assign cfg_cmd = (cyc_cmd == phb_pkg::CMD_CFG_RD)
                   || (cyc_cmd == phb_pkg::CMD_CFG_WR);
    assign positive = cfg_cmd
        || (mem_cmd && cyc_addr >= phb_pkg::DRAM_BASE
                    && cyc_addr <  phb_pkg::DRAM_LIMIT)
        || (mem_cmd && cyc_addr >= phb_pkg::BOOT_BASE)
        || (io_cmd  && cyc_addr >= phb_pkg::EMB_IO_BASE
                    && cyc_addr <  phb_pkg::EMB_IO_LIMIT);
    assign subtract = (io_cmd && cyc_addr < phb_pkg::IO_LOW_LIMIT)
        || (mem_cmd && cyc_addr < phb_pkg::MEM_LOW_LIMIT);
    // Memory data is handled elsewhere, so only config and I/O own lines.
    assign owned    = cfg_cmd || io_cmd;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg <= PHT_IDLE;
            wait_reg  <= 2'h0;
            cyc_addr  <= 32'h0;
            cyc_cmd   <= 4'h0;
            devsel_n  <= 1'b1;
            trdy_n    <= 1'b1;
            active    <= 1'b0;
        end else begin
            case (state_reg)
                PHT_IDLE: begin
                    if (!frame_n) begin
                        cyc_addr  <= ad_in;
                        cyc_cmd   <= ~cbe_n_in;
                        wait_reg  <= 2'h0;
                        state_reg <= PHT_DECODE;
                    end
                end
                PHT_DECODE: begin
                    wait_reg <= wait_reg + 2'h1;
                    if (positive || (subtract && devsel_in_n
                        && wait_reg == 2'(phb_pkg::SUBTR_DELAY - 1))) begin
                        devsel_n  <= 1'b0;
                        active    <= 1'b1;
                        state_reg <= PHT_DATA;
                    end else if (wait_reg == 2'(phb_pkg::SUBTR_DELAY - 1)
                                 || !devsel_in_n) begin
                        state_reg <= PHT_TURN;
                    end
                end
                PHT_DATA: begin
                    // Single data phase; read data must be valid now.
                    trdy_n <= 1'b0;
                    if (!trdy_n && !irdy_n) begin
                        trdy_n    <= 1'b1;
                        devsel_n  <= 1'b1;
                        active    <= 1'b0;
                        state_reg <= PHT_TURN;
                    end
                end
                PHT_TURN: begin
                    if (frame_n) begin
                        state_reg <= PHT_IDLE;
                    end
                end
                default: state_reg <= PHT_IDLE;
            endcase
        end
    end

    assign drive_ad = active && owned
                   && phb_pkg::is_read(cyc_cmd);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wr_strobe <= 1'b0;
            wr_data   <= 32'h0;
        end else begin
            wr_strobe <= 1'b0;
            if (state_reg == PHT_DATA && !trdy_n && !irdy_n && owned
                && !phb_pkg::is_read(cyc_cmd)) begin
                wr_strobe <= 1'b1;
                wr_data   <= ad_in;
            end
        end
    end

    // Returned data is never used here; the device end registers it onto the lines.
    logic unused_rd;
    assign unused_rd = ^rd_data;
endmodule : phb_target

// File: sim/phb_bus_asserts.sv
// Checker for the local bus joining the chipset end and the agent end.
// Assumes instantiation beside the interface, every pin named.
`timescale 1ns/1ps
module phb_bus_asserts (
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic [31:0] ad_dev_o,
    input wire logic        ad_dev_oe_n,
    input wire logic        ad_ext_oe_n,
    input wire logic [3:0]  cbe_n_i,
    input wire logic        par_dev_o,
    input wire logic        par_dev_oe_n,
    input wire logic        frame_n_i,
    input wire logic        irdy_n_i,
    input wire logic        trdy_n_i,
    input wire logic        devsel_n_i,
    input wire logic [2:0]  master_grant_n
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_frame_start;
        $fell(frame_n_i);
    endsequence
    sequence s_parity_next;
        !par_dev_oe_n && (par_dev_o == ^{$past(ad_dev_o), $past(cbe_n_i)});
    endsequence
    a_par_follows_ad: assert property (!ad_dev_oe_n |=> s_parity_next)
        else $error("parity wrong or late after driven phase");
    a_ad_when_claimed: assert property (!ad_dev_oe_n |->
        !devsel_n_i || !$past(devsel_n_i))
        else $error("address data driven without a claim");
    a_ad_no_clash: assert property (ad_dev_oe_n || ad_ext_oe_n)
        else $error("both ends drive address data");
    a_trdy_stands: assert property (!trdy_n_i && irdy_n_i |=> !trdy_n_i)
        else $error("target ready dropped before transfer");
    a_trdy_claimed: assert property (!trdy_n_i |-> !devsel_n_i)
        else $error("target ready without device select");
    a_devsel_stands: assert property (!devsel_n_i && (irdy_n_i || trdy_n_i)
        |=> !devsel_n_i)
        else $error("device select dropped before transfer");
    a_frame_single: assert property (s_frame_start |=> frame_n_i)
        else $error("frame held past the single phase");
    a_irdy_after_frame: assert property (s_frame_start |=> !irdy_n_i)
        else $error("initiator ready late after frame");
    a_irdy_holds: assert property (!irdy_n_i && trdy_n_i && !devsel_n_i
        |=> !irdy_n_i)
        else $error("initiator ready dropped before transfer");
    a_grant_single: assert property ($onehot0(~master_grant_n))
        else $error("more than one grant");
endmodule : phb_bus_asserts

// File: sim/tb.sv
// Self-checking bench joining the chipset end and the agent end.
// Assumes the package, interface, both ends and the checker come first.
`timescale 1ns/1ps
module tb;
    localparam int unsigned HOLD = 20;
    localparam logic [31:0] T_ADDR [9] = '{32'h0000_0800, 32'h0000_0804,
        32'h0000_f010, 32'h0000_3ffc, 32'h0000_4000, 32'h1000_0000,
        32'h00ff_fffc, 32'h0100_0000, 32'hfff0_0000};
    localparam logic [3:0]  T_CMD [9] = '{phb_pkg::CMD_CFG_RD,
        phb_pkg::CMD_CFG_WR, phb_pkg::CMD_IO_WR, phb_pkg::CMD_IO_RD,
        phb_pkg::CMD_IO_RD, phb_pkg::CMD_MEM_RD, phb_pkg::CMD_MEM_WR,
        phb_pkg::CMD_MEM_RD, phb_pkg::CMD_MEM_RD};
    localparam logic [8:0]  T_MISS = 9'h090;
    logic        core_clk, rst_b, main_power_good, nmi_enable, start;
    logic        serr_req, lock_n, wr_strobe, locked, nmi, done, no_claim;
    logic        dev_drove, seen_wr;
    logic [31:0] rd_data, addr, wdata, wr_data, cyc_addr, rdata, got_wr;
    logic [7:0]  int_route;
    logic [3:0]  cmd, irq_n, cyc_cmd, irq_to_ctrl;
    logic [1:0]  req_hi_n;
    int          n_errors, checks_done, k;
    phb_bus_if bus ();
    // Released lines float to the pull-up level, as on the board.
    assign bus.ad_i = !bus.ad_dev_oe_n ? bus.ad_dev_o :
                      !bus.ad_ext_oe_n ? bus.ad_ext_o : 32'hffff_ffff;
    assign bus.cbe_n_i = !bus.cbe_dev_oe_n ? bus.cbe_n_dev_o :
                         !bus.cbe_ext_oe_n ? bus.cbe_n_ext_o : 4'hf;
    assign bus.par_i = !bus.par_dev_oe_n ? bus.par_dev_o :
                       !bus.par_ext_oe_n ? bus.par_ext_o : 1'b1;
    assign bus.frame_n_i  = bus.frame_ext_oe_n | bus.frame_n_ext_o;
    assign bus.irdy_n_i   = bus.irdy_ext_oe_n | bus.irdy_n_ext_o;
    assign bus.trdy_n_i   = bus.trdy_dev_oe_n | bus.trdy_n_dev_o;
    assign bus.stop_n_i   = bus.stop_dev_oe_n | bus.stop_n_dev_o;
    assign bus.devsel_n_i = bus.devsel_dev_oe_n | bus.devsel_n_dev_o;
    assign bus.lock_n_i   = lock_n;
    assign bus.master_request_n[2:1] = req_hi_n;
    phb_device_end #(.RESET_HOLD(HOLD)) u_phb_device_end (
        .core_clk(core_clk), .rst_b(rst_b), .bus(bus),
        .main_power_good(main_power_good), .nmi_enable(nmi_enable),
        .rd_data(rd_data), .int_route(int_route), .wr_strobe(wr_strobe),
        .wr_data(wr_data), .cyc_addr(cyc_addr), .cyc_cmd(cyc_cmd),
        .locked(locked), .irq_to_ctrl(irq_to_ctrl), .nmi(nmi));
    phb_ext_master u_phb_ext_master (
        .core_clk(core_clk), .rst_b(rst_b), .bus(bus), .start(start),
        .addr(addr), .cmd(cmd), .wdata(wdata), .irq_n(irq_n),
        .serr_req(serr_req), .busy(), .done(done), .no_claim(no_claim),
        .rdata(rdata));
    phb_bus_asserts u_phb_bus_asserts (
        .core_clk(core_clk), .rst_b(rst_b), .ad_dev_o(bus.ad_dev_o),
        .ad_dev_oe_n(bus.ad_dev_oe_n), .ad_ext_oe_n(bus.ad_ext_oe_n),
        .cbe_n_i(bus.cbe_n_i), .par_dev_o(bus.par_dev_o),
        .par_dev_oe_n(bus.par_dev_oe_n), .frame_n_i(bus.frame_n_i),
        .irdy_n_i(bus.irdy_n_i), .trdy_n_i(bus.trdy_n_i),
        .devsel_n_i(bus.devsel_n_i), .master_grant_n(bus.master_grant_n));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        dev_drove <= start ? 1'b0 : (dev_drove | ~bus.ad_dev_oe_n);
        seen_wr   <= start ? 1'b0 : (seen_wr | wr_strobe);
        if (wr_strobe) got_wr <= wr_data;
    end
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check
    task automatic finish_test;
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : finish_test
    task automatic settle(input int n);
        repeat (n) @(negedge core_clk);
    endtask : settle
    task automatic xfer(input logic [31:0] a, input logic [3:0] c,
                        input logic [31:0] d);
        int w;
        @(posedge core_clk);
        start <= 1'b1;
        addr  <= a;
        cmd   <= c;
        wdata <= d;
        @(posedge core_clk);
        start <= 1'b0;
        w = 0;
        while (done !== 1'b1 && w < 80) begin
            @(negedge core_clk);
            w++;
        end
        check(w < 80, "transfer never completed");
        if (w >= 80) finish_test();
    endtask : xfer
    initial begin
        rst_b = 1'b0; main_power_good = 1'b0; nmi_enable = 1'b0;
        rd_data = 32'h5a5a_c3c3; int_route = 8'h1b; start = 1'b0;
        addr = 32'h0; cmd = 4'h0; wdata = 32'h0; irq_n = 4'hf;
        serr_req = 1'b0; lock_n = 1'b1; req_hi_n = 2'h3;
        n_errors = 0; checks_done = 0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        settle(5);
        check(bus.bus_reset_out_n === 1'b0, "bus reset not held");
        @(posedge core_clk);
        main_power_good <= 1'b1;
        k = 0;
        while (bus.bus_reset_out_n !== 1'b1 && k < 100) begin
            @(negedge core_clk);
            k++;
        end
        check(k >= HOLD && k <= HOLD + 4, "bus reset hold length");
        if (k >= 100) finish_test();
        for (int i = 0; i < 9; i++) begin
            xfer(T_ADDR[i], T_CMD[i], 32'hc0de_0000 | 32'(i));
            check(no_claim === T_MISS[i], "claim decision");
            check(cyc_addr === T_ADDR[i] && cyc_cmd === T_CMD[i],
                  "address phase not latched");
            if (T_CMD[i] == phb_pkg::CMD_MEM_RD ||
                T_CMD[i] == phb_pkg::CMD_MEM_WR)
                check(dev_drove === 1'b0, "memory data driven");
            else if (!T_MISS[i] && T_CMD[i][0] == 1'b0)
                check(rdata === rd_data && dev_drove === 1'b1,
                      "read data");
            else if (!T_MISS[i] && T_CMD[i][0] == 1'b1)
                check(seen_wr === 1'b1 && got_wr === (32'hc0de_0000 |
                      32'(i)), "write data");
        end
        // The lock is taken only at a frame start, so a cycle is run.
        @(posedge core_clk);
        lock_n <= 1'b0;
        xfer(T_ADDR[0], T_CMD[0], 32'h0);
        settle(2);
        check(locked === 1'b1, "lock not taken");
        @(posedge core_clk);
        lock_n <= 1'b1;
        xfer(T_ADDR[0], T_CMD[0], 32'h0);
        settle(4);
        check(locked === 1'b0, "lock not released");
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            irq_n <= ~(4'h1 << i);
            settle(8);
            check(irq_to_ctrl === (4'h8 >> i), "interrupt route");
        end
        @(posedge core_clk);
        serr_req <= 1'b1;
        req_hi_n <= 2'h2;
        settle(8);
        check(nmi === 1'b0, "nmi while disabled");
        check(bus.master_grant_n === 3'h5, "grant to request one");
        @(posedge core_clk);
        nmi_enable <= 1'b1;
        req_hi_n   <= 2'h3;
        settle(8);
        check(nmi === 1'b1, "nmi missing");
        @(posedge core_clk);
        main_power_good <= 1'b0;
        settle(4);
        check(bus.bus_reset_out_n === 1'b0, "bus reset on power loss");
        finish_test();
    end
endmodule : tb
